/* File: hdl/gedt_pkg.sv */
package gedt_pkg;
  localparam int unsigned GEDT_WIDTH      = 16;
  localparam int unsigned GEDT_DIV_EIGHT  = 8;
  localparam int unsigned GEDT_DIV_THIRTY = 32;
  localparam logic [15:0] GEDT_ALL_ONES   = 16'hFFFF;
  localparam logic [15:0] GEDT_ZERO       = 16'h0000;
  localparam logic [15:0] GEDT_ONE        = 16'h0001;
  localparam logic [15:0] GEDT_RESET_VAL  = 16'h0000;

  // Timer mode count source selection
  typedef enum logic [1:0] {
    GEDT_SRC_UNDIV,
    GEDT_SRC_DIV8,
    GEDT_SRC_DIV32,
    GEDT_SRC_SUB32
  } gedt_src_t;

  // Gate function selection
  typedef enum logic [1:0] {
    GEDT_GATE_OFF,
    GEDT_GATE_LOW,
    GEDT_GATE_HIGH
  } gedt_gate_t;

  // Event counter source selection
  typedef enum logic [1:0] {
    GEDT_EVT_FALL,
    GEDT_EVT_RISE,
    GEDT_EVT_TIMER
  } gedt_evt_t;
endpackage

/* File: hdl/gedt_prescaler.sv */
`timescale 1ns/100ps
// Produces one-cycle ticks for the three divided internal count sources.
module gedt_prescaler #(
  parameter int unsigned DIV_A = gedt_pkg::GEDT_DIV_EIGHT,
  parameter int unsigned DIV_B = gedt_pkg::GEDT_DIV_THIRTY
) (
  // Clock and reset
  input  wire logic clock,
  input  wire logic rst_n,
  // Secondary clock, sampled as a synchronous level
  input  wire logic sub_clock,
  // Ticks
  output logic      tick_div_a,
  output logic      tick_div_b,
  output logic      tick_sub_b
);
  import gedt_pkg::*;

  // One counter serves both main ticks, so the second divisor must be a multiple of the first
  if (DIV_A < 2 || DIV_B < 2 || (DIV_B % DIV_A) != 0) begin : g_div_check
    $error("gedt_prescaler: divisors must be at least 2 and nest");
  end

  localparam int unsigned CW = $clog2(DIV_B);

  logic [CW-1:0] main_cnt_q;
  logic [CW-1:0] sub_cnt_q;
  logic          sub_prev_q;
  wire           sub_rise = sub_clock & ~sub_prev_q;

  always_ff @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
      main_cnt_q <= '0;
      sub_cnt_q  <= '0;
      sub_prev_q <= 1'b0;
    end else begin
      main_cnt_q <= (main_cnt_q == CW'(DIV_B - 1)) ? '0 : main_cnt_q + 1'b1;
      sub_prev_q <= sub_clock;
      if (sub_rise) begin
        sub_cnt_q <= (sub_cnt_q == CW'(DIV_B - 1)) ? '0 : sub_cnt_q + 1'b1;
      end
    end
  end

  // Divide-by-eight is taken from the low bits of the same counter
  assign tick_div_a = (CW'(main_cnt_q % CW'(DIV_A)) == CW'(DIV_A - 1));
  assign tick_div_b = (main_cnt_q == CW'(DIV_B - 1));
  assign tick_sub_b = sub_rise && (sub_cnt_q == CW'(DIV_B - 1));
endmodule // gedt_prescaler

/* File: hdl/gedt_timer.sv */
`timescale 1ns/100ps
module gedt_timer #(
  parameter int unsigned WIDTH = gedt_pkg::GEDT_WIDTH
) (
  // Clock and reset
  input  wire logic                     clock,
  input  wire logic                     rst_n,
  input  wire logic                     sub_clock,
  // Control
  input  wire logic                     count_start,
  input  wire logic                     event_mode,
  input  wire logic                     free_run,
  input  wire logic                     pulse_out_en,
  input  wire gedt_pkg::gedt_src_t      src_sel,
  input  wire gedt_pkg::gedt_gate_t     gate_sel,
  input  wire gedt_pkg::gedt_evt_t      evt_sel,
  input  wire logic                     updown_flag,
  input  wire logic                     dir_from_pin,
  // Timer register access
  input  wire logic                     wr_en,
  input  wire logic [WIDTH-1:0]         wr_data,
  output logic      [WIDTH-1:0]         count_value,
  output logic      [WIDTH-1:0]         reload_value,
  // Pins and neighbour
  input  wire logic                     timer_input_pin,
  input  wire logic                     timer_output_pin_in,
  input  wire logic                     neighbour_overflow,
  output logic                          timer_output_pin,
  output logic                          timer_output_pin_oe,
  // Status
  output logic                          irq_request
);
  import gedt_pkg::*;

  if (WIDTH != GEDT_WIDTH) begin : g_width_check
    $error("gedt_timer: only a 16-bit counter is supported");
  end

  logic [WIDTH-1:0] cnt_q, cnt_d;
  logic [WIDTH-1:0] reload_q;
  logic             in_prev_q;
  logic             out_q;
  logic             irq_q;

  logic tick_div_a;
  logic tick_div_b;
  logic tick_sub_b;

  gedt_prescaler u_prescaler (
    .clock      (clock),
    .rst_n      (rst_n),
    .sub_clock  (sub_clock),
    .tick_div_a (tick_div_a),
    .tick_div_b (tick_div_b),
    .tick_sub_b (tick_sub_b)
  );

  // Internal source select
  wire src_tick = (src_sel == GEDT_SRC_UNDIV) ? 1'b1 :
                  (src_sel == GEDT_SRC_DIV8)  ? tick_div_a :
                  (src_sel == GEDT_SRC_DIV32) ? tick_div_b : tick_sub_b;

  // Gate: the pin is sampled directly, so short gate pulses are only as good as
  // the source spacing the external driver respects
  wire gate_open = (gate_sel == GEDT_GATE_OFF)  ? 1'b1 :
                   (gate_sel == GEDT_GATE_LOW)  ? ~timer_input_pin :
                   (gate_sel == GEDT_GATE_HIGH) ? timer_input_pin : 1'b1;

  // Event edges
  wire fall_edge = in_prev_q & ~timer_input_pin;
  wire rise_edge = ~in_prev_q & timer_input_pin;
  wire evt_tick  = (evt_sel == GEDT_EVT_FALL) ? fall_edge :
                   (evt_sel == GEDT_EVT_RISE) ? rise_edge : neighbour_overflow;

  // Direction sampled at the edge itself, so a change counts from the next one
  wire count_up  = event_mode & (dir_from_pin ? timer_output_pin_in : updown_flag);

  wire tick      = count_start & (event_mode ? evt_tick : (src_tick & gate_open));
  wire at_zero   = (cnt_q == GEDT_ZERO);
  wire at_ones   = (cnt_q == GEDT_ALL_ONES);
  wire wrap      = tick & (count_up ? at_ones : at_zero);
  wire reloads   = ~event_mode | ~free_run;

  // Reload on wrap yields the value+1 (down) and FFFF-value+1 (up) ratios
  always_comb begin
    cnt_d = cnt_q;
    if (wr_en && !count_start) begin
      cnt_d = wr_data;
    end else if (wrap && reloads) begin
      cnt_d = reload_q;
    end else if (tick && count_up) begin
      cnt_d = cnt_q + GEDT_ONE;
    end else if (tick) begin
      cnt_d = cnt_q - GEDT_ONE;
    end
  end

  always_ff @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
      cnt_q     <= GEDT_RESET_VAL;
      reload_q  <= GEDT_RESET_VAL;
      in_prev_q <= 1'b0;
      out_q     <= 1'b0;
      irq_q     <= 1'b0;
    end else begin
      cnt_q     <= cnt_d;
      in_prev_q <= timer_input_pin;
      irq_q     <= wrap;
      if (wr_en) begin
        reload_q <= wr_data;
      end
      if (!count_start || !pulse_out_en) begin
        out_q <= 1'b0;
      end else if (wrap) begin
        out_q <= ~out_q;
      end
    end
  end

  assign count_value         = cnt_q;
  assign reload_value        = reload_q;
  assign timer_output_pin    = out_q;
  // Pin becomes an input when it supplies the count direction
  assign timer_output_pin_oe = pulse_out_en & ~(event_mode & dir_from_pin);
  assign irq_request         = irq_q;

  property p_hold_when_stopped;
    @(posedge clock) disable iff (!rst_n)
      (!count_start && !wr_en) |=> (cnt_q == $past(cnt_q));
  endproperty
  a_hold_when_stopped: assert property (p_hold_when_stopped)
    else $error("counter moved while stopped");

  property p_gate_freeze;
    @(posedge clock) disable iff (!rst_n)
      (!event_mode && gate_sel == GEDT_GATE_HIGH && !timer_input_pin && !wr_en)
        |=> (cnt_q == $past(cnt_q));
  endproperty
  a_gate_freeze: assert property (p_gate_freeze)
    else $error("counter moved with gate closed");

  property p_gate_count;
    @(posedge clock) disable iff (!rst_n)
      (!event_mode && count_start && gate_sel == GEDT_GATE_HIGH && timer_input_pin
       && src_sel == GEDT_SRC_UNDIV && !at_zero)
        |=> (cnt_q == $past(cnt_q) - GEDT_ONE);
  endproperty
  a_gate_count: assert property (p_gate_count)
    else $error("counter did not decrement with gate open");

  property p_underflow_reload;
    @(posedge clock) disable iff (!rst_n)
      (tick && !event_mode && at_zero && !wr_en) |=> (cnt_q == $past(reload_q)) && irq_q;
  endproperty
  a_underflow_reload: assert property (p_underflow_reload)
    else $error("underflow did not reload");

  property p_up_reload;
    @(posedge clock) disable iff (!rst_n)
      (tick && event_mode && !free_run && count_up && at_ones)
        |=> (cnt_q == $past(reload_q)) && irq_q;
  endproperty
  a_up_reload: assert property (p_up_reload)
    else $error("overflow did not reload");

  property p_free_wrap;
    @(posedge clock) disable iff (!rst_n)
      (tick && event_mode && free_run && !count_up && at_zero)
        |=> (cnt_q == GEDT_ALL_ONES) && irq_q;
  endproperty
  a_free_wrap: assert property (p_free_wrap)
    else $error("free-run wrap wrong");

  property p_toggle;
    @(posedge clock) disable iff (!rst_n)
      (wrap && pulse_out_en && count_start) |=> (out_q != $past(out_q));
  endproperty
  a_toggle: assert property (p_toggle)
    else $error("output did not toggle on underflow");

  property p_stop_low;
    @(posedge clock) disable iff (!rst_n)
      !count_start |=> !timer_output_pin;
  endproperty
  a_stop_low: assert property (p_stop_low)
    else $error("output not low after stop");

  property p_write_running;
    @(posedge clock) disable iff (!rst_n)
      (wr_en && count_start && !tick) |=> (reload_q == $past(wr_data)) && (cnt_q == $past(cnt_q));
  endproperty
  a_write_running: assert property (p_write_running)
    else $error("running write touched counter");

  property p_write_stopped;
    @(posedge clock) disable iff (!rst_n)
      (wr_en && !count_start) |=> (cnt_q == $past(wr_data)) && (reload_q == $past(wr_data));
  endproperty
  a_write_stopped: assert property (p_write_stopped)
    else $error("stopped write did not load counter and reload");

  // A driven pin would fight the level that sets the direction
  property p_oe_released;
    @(posedge clock) disable iff (!rst_n)
      (event_mode && dir_from_pin) |-> !timer_output_pin_oe;
  endproperty
  a_oe_released: assert property (p_oe_released)
    else $error("output pin driven while it sets the direction");

  sequence s_free_up_wrap;
    tick && event_mode && free_run && count_up && at_ones;
  endsequence

  property p_free_up_wrap;
    @(posedge clock) disable iff (!rst_n)
      s_free_up_wrap |=> (cnt_q == GEDT_ZERO) && irq_q;
  endproperty
  a_free_up_wrap: assert property (p_free_up_wrap)
    else $error("free-run up wrap did not reach zero");
endmodule // gedt_timer

/* File: tb/gedt_pin_model.sv */
`timescale 1ns/100ps
// Far side of the timer pins
module gedt_pin_model (
  // Clock
  input  wire logic clock,
  // Levels asked for by the bench
  input  wire logic pin_req,
  input  wire logic dir_req,
  // Output pin as driven by the device
  input  wire logic out_drv,
  input  wire logic out_oe,
  // Pin levels
  output logic      timer_input_pin,
  output logic      out_wire
);
  // Levels move on clean edges only; the bench holds each one long enough
  always_ff @(posedge clock) begin
    timer_input_pin <= pin_req;
  end
  // A released output pin carries the far side's direction level
  assign out_wire = out_oe ? out_drv : dir_req;
endmodule // gedt_pin_model

/* File: tb/test_gated_event_down_up_timer.sv */
`timescale 1ns/100ps
module test_gated_event_down_up_timer;
  import gedt_pkg::*;
  logic        clock = 0, rst_n = 0, sub_clock = 0, count_start = 0, event_mode = 0;
  logic        free_run = 0, pulse_out_en = 0, updown_flag = 0, dir_from_pin = 0;
  logic        wr_en = 0, nb_ovf = 0, pin_req = 0, dir_req = 0, pin_in, pin_w, out_q, out_oe, irq;
  logic [15:0] wr_data = 0, cnt, rld, exp, rl, ni, m, irq_seen = 0;
  logic [1:0]  sc = 0;
  gedt_src_t   src_sel = GEDT_SRC_UNDIV;
  gedt_gate_t  gate_sel = GEDT_GATE_OFF;
  gedt_evt_t   evt_sel = GEDT_EVT_FALL;
  int          err_count = 0, n_checks = 0, seed, n, k;

  gedt_timer uut (.clock(clock), .rst_n(rst_n), .sub_clock(sub_clock),
    .count_start(count_start), .event_mode(event_mode), .free_run(free_run),
    .pulse_out_en(pulse_out_en), .src_sel(src_sel), .gate_sel(gate_sel), .evt_sel(evt_sel),
    .updown_flag(updown_flag), .dir_from_pin(dir_from_pin), .wr_en(wr_en), .wr_data(wr_data),
    .count_value(cnt), .reload_value(rld), .timer_input_pin(pin_in),
    .timer_output_pin_in(pin_w), .neighbour_overflow(nb_ovf), .timer_output_pin(out_q),
    .timer_output_pin_oe(out_oe), .irq_request(irq));
  gedt_pin_model pins (.clock(clock), .pin_req(pin_req), .dir_req(dir_req), .out_drv(out_q),
    .out_oe(out_oe), .timer_input_pin(pin_in), .out_wire(pin_w));

  always #10 clock = ~clock;
  // Secondary clock rises every fourth cycle
  always @(posedge clock) begin
    sc <= sc + 2'd1;
    sub_clock <= sc[1];
    irq_seen <= irq_seen + 16'(irq === 1'b1);
  end

  task automatic chk(input logic [15:0] seen, input logic [15:0] want);
    n_checks++;
    if (seen !== want) begin
      err_count++;
      $display("[ERR] %0t seen %h expected %h", $time, seen, want);
    end
  endtask
  task automatic clk(input int c);
    repeat (c) @(posedge clock);
  endtask
  task automatic stop_test();
    $display("checks %0d errors %0d", n_checks, err_count);
    if (err_count == 0 && n_checks > 0) $display("All checks passed");
    else $display("Checks failed");
    $finish;
  endtask
  // Load while stopped, then start counting
  task automatic ld(input logic [15:0] v);
    @(posedge clock) count_start <= 0;
    wr_en <= 1;
    wr_data <= v;
    @(posedge clock) wr_en <= 0;
    count_start <= 1;
    rl = v;
    exp = v;
    #1 chk(cnt, v);
    chk(rld, v);
  endtask
  task automatic wchg(output int c);
    logic [15:0] o;
    o = cnt;
    c = 0;
    while (cnt === o && c < 400) begin
      // Look just after the edge, once the count has settled
      clk(1);
      #1;
      c++;
    end
  endtask
  // One pin pulse and one neighbour pulse: exactly one count whatever the source
  task automatic ev(input gedt_evt_t e, input logic up, input logic fr, input logic dp);
    logic w;
    @(posedge clock) evt_sel <= e;
    free_run <= fr;
    dir_from_pin <= dp;
    dir_req <= up;
    updown_flag <= up ^ dp;
    w = up ? (exp == 16'hFFFF) : (exp == 16'h0000);
    exp = w ? (fr ? ~exp : rl) : (up ? exp + 16'h0001 : exp - 16'h0001);
    ni = ni + 16'(w);
    clk(3);
    pin_req <= 1;
    clk(3);
    pin_req <= 0;
    nb_ovf <= 1;
    clk(1);
    nb_ovf <= 0;
    clk(6);
    #1 chk(cnt, exp);
    chk(irq_seen, ni);
  endtask

  initial begin
    #400000;
    err_count++;
    stop_test();
  end

  initial begin
    seed = 1471;
    clk(16);
    rst_n <= 1;
    n = 3 + ($unsigned($random(seed)) % 8);
    m = 16'($random(seed));
    pulse_out_en <= 1;
    ld(16'(n));
    clk(n);
    #1 chk(cnt, 16'h0000);
    clk(1);
    #1 chk(cnt, 16'(n));
    chk({15'h0000, irq}, 16'h0001);
    chk({15'h0000, out_q}, 16'h0001);
    chk({15'h0000, out_oe}, 16'h0001);
    @(posedge clock) wr_en <= 1;
    wr_data <= m;
    @(posedge clock) wr_en <= 0;
    count_start <= 0;
    #1 chk(rld, m);
    chk(cnt, 16'(n - 2));
    clk(3);
    #1 chk(cnt, 16'(n - 2));
    chk({15'h0000, out_q}, 16'h0000);
    @(posedge clock) pulse_out_en <= 0;
    for (int i = 1; i <= 2; i++) begin
      @(posedge clock) gate_sel <= gedt_gate_t'(i);
      pin_req <= (i == 1);
      ld(16'h0100);
      clk(6);
      #1 chk(cnt, 16'h0100);
      n = 4 + ($unsigned($random(seed)) % 4);
      @(posedge clock) pin_req <= (i != 1);
      clk(n);
      pin_req <= (i == 1);
      clk(6);
      #1 chk(cnt, 16'h0100 - 16'(n));
    end
    @(posedge clock) gate_sel <= GEDT_GATE_OFF;
    for (int i = 1; i <= 3; i++) begin
      @(posedge clock) src_sel <= gedt_src_t'(i);
      ld(16'h0100);
      wchg(k);
      wchg(k);
      chk(16'(k), i == 1 ? 16'h0008 : (i == 2 ? 16'h0020 : 16'h0080));
    end
    @(posedge clock) event_mode <= 1;
    ld(16'hFFFE);
    ni = irq_seen;
    ev(GEDT_EVT_FALL, 1, 1, 0);
    ev(GEDT_EVT_FALL, 1, 1, 0);
    ev(GEDT_EVT_RISE, 0, 1, 0);
    ev(GEDT_EVT_TIMER, 1, 0, 0);
    // Drive enabled: a pin left driven would flip the count direction
    @(posedge clock) pulse_out_en <= 1;
    ev(GEDT_EVT_FALL, 1, 0, 1);
    chk({15'h0000, out_oe}, 16'h0000);
    ld(16'h0000);
    ni = irq_seen;
    // Running write: reload takes a fresh value while the counter holds zero
    @(posedge clock) wr_en <= 1;
    wr_data <= m;
    @(posedge clock) wr_en <= 0;
    rl = m;
    #1 chk(rld, m);
    chk(cnt, 16'h0000);
    ev(GEDT_EVT_FALL, 0, 0, 0);
    chk({15'h0000, out_q}, 16'h0001);
    stop_test();
  end
endmodule // test_gated_event_down_up_timer
